// file: hdl/dcs_channel.sv
`timescale 1ns/1ps
`default_nettype none
module dcs_channel (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        emu_halt,
    input  wire logic        host_to_processor_event,
    input  wire logic        external_interrupt_four,
    input  wire logic        external_interrupt_five,
    input  wire logic        external_interrupt_six,
    input  wire logic        external_interrupt_seven,
    output logic             rd_req,
    output logic      [31:0] rd_addr,
    output logic      [1:0]  rd_region,
    input  wire logic        rd_ack,
    input  wire logic [31:0] rd_data,
    output logic             wr_req,
    output logic      [31:0] wr_addr,
    output logic      [31:0] wr_data,
    output logic      [1:0]  wr_region,
    input  wire logic        wr_ack
);
    import dcs_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_RD_WAIT, ST_RD, ST_WR_WAIT, ST_WR} dcs_state_t;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [1:0] region_of(input logic [31:0] a);
        if (a < EXT_BASE) begin
            region_of = REG_PROG;
        end else if (a < PERIPH_BASE) begin
            region_of = REG_EXT;
        end else begin
            region_of = REG_PERIPH;
        end
    endfunction

    function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] m,
                                               input logic [15:0] ei, input logic [15:0] fi,
                                               input logic last);
        case (m)
            STEP_INC:   step_addr = a + ELEM_BYTES;
            STEP_DEC:   step_addr = a - ELEM_BYTES;
            STEP_INDEX: step_addr = a + {{16{(last ? fi[15] : ei[15])}}, (last ? fi : ei)};
            default:    step_addr = a;
        endcase
    endfunction

    function automatic logic sel_hit(input logic [4:0] sel, input logic [4:0] ev);
        if (sel == SEL_HOST) begin
            sel_hit = ev[4];
        end else if (sel >= SEL_EXT4 && sel < SEL_EXT4 + 5'h04) begin
            sel_hit = ev[sel[1:0]];
        end else begin
            sel_hit = 1'b0;
        end
    endfunction

    // ----------------------------------------
    // Event synchroniser
    // ----------------------------------------
    logic [4:0] ev_pulse;
    dcs_event_sync #(.N(5)) dcs_event_sync_inst (
        .pclk       (pclk),
        .presetn    (presetn),
        .async_in   ({host_to_processor_event, external_interrupt_seven, external_interrupt_six,
                      external_interrupt_five, external_interrupt_four}),
        .rise_pulse (ev_pulse)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    dcs_state_t  state_reg,   state_next;
    logic [31:0] ctrl_reg,    ctrl_next;
    logic [31:0] src_reg,     src_next;
    logic [31:0] dst_reg,     dst_next;
    logic [31:0] count_reg,   count_next;
    logic [31:0] index_reg,   index_next;
    logic [31:0] scur_reg,    scur_next;
    logic [31:0] dcur_reg,    dcur_next;
    logic [15:0] eleft_reg,   eleft_next;
    logic [15:0] fleft_reg,   fleft_next;
    logic        first_reg,   first_next;
    logic [31:0] data_reg,    data_next;
    logic        rdev_reg,    rdev_next;
    logic        wrev_reg,    wrev_next;
    logic        done_reg,    done_next;
    logic        rreq_reg,    rreq_next;
    logic        wreq_reg,    wreq_next;
    logic [1:0]  rreg_reg,    rreg_next;
    logic [1:0]  wreg_reg,    wreg_next;
    logic [31:0] prdata_reg,  prdata_next;
    logic        pready_reg,  pready_next;
    logic        pslverr_reg, pslverr_next;

    logic [4:0]  rsel, wsel;
    logic [1:0]  sstep, dstep;
    logic        emulation_pause_enable, hold, read_sync_select_need, write_sync_select_need, last_elem, acc, wr_acc, go, mapped;
    logic        rdev_set, wrev_set;
    logic [31:0] status;

    always_comb begin
        rsel       = ctrl_reg[CTL_RSEL_LSB +: 5];
        wsel       = ctrl_reg[CTL_WSEL_LSB +: 5];
        sstep      = ctrl_reg[CTL_SSTEP_LSB +: 2];
        dstep      = ctrl_reg[CTL_DSTEP_LSB +: 2];
        emulation_pause_enable       = ctrl_reg[CTL_EMU_BIT];
        hold       = (ctrl_reg[CTL_START_LSB +: 2] == START_PAUSE) || (emu_halt && emulation_pause_enable);
        read_sync_select_need = (rsel != SEL_NONE) && (!ctrl_reg[CTL_FSYNC_BIT] || first_reg);
        write_sync_select_need = (wsel != SEL_NONE);
        rdev_set   = sel_hit(rsel, ev_pulse);
        wrev_set   = sel_hit(wsel, ev_pulse);
        last_elem  = (eleft_reg == 16'h0001);
        acc        = psel && penable && pready_reg;
        wr_acc     = acc && pwrite;
        go         = wr_acc && (paddr == OFS_CTRL) && (pwdata[CTL_START_LSB +: 2] == START_RUN)
                     && (state_reg == ST_IDLE);
        mapped     = (paddr[1:0] == 2'h0) && (paddr <= OFS_DST_CUR);
        status     = {24'h0, wreg_reg, rreg_reg, done_reg, rdev_reg || wrev_reg, hold,
                      state_reg != ST_IDLE};
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        state_next   = state_reg;
        ctrl_next    = ctrl_reg;
        src_next     = src_reg;
        dst_next     = dst_reg;
        count_next   = count_reg;
        index_next   = index_reg;
        scur_next    = scur_reg;
        dcur_next    = dcur_reg;
        eleft_next   = eleft_reg;
        fleft_next   = fleft_reg;
        first_next   = first_reg;
        data_next    = data_reg;
        done_next    = done_reg;
        rreq_next    = rreq_reg;
        wreq_next    = wreq_reg;
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        pready_next  = psel && penable && !pready_reg;
        // Set wins over consume
        rdev_next    = rdev_set || (rdev_reg && !(rreq_reg && rd_ack && read_sync_select_need));
        wrev_next    = wrev_set || (wrev_reg && !(wreq_reg && wr_ack && write_sync_select_need));
        if (psel && penable && !pready_reg) begin
            pslverr_next = !mapped;
            if (paddr == OFS_CTRL) begin
                prdata_next = ctrl_reg;
            end else if (paddr == OFS_SRC) begin
                prdata_next = src_reg;
            end else if (paddr == OFS_DST) begin
                prdata_next = dst_reg;
            end else if (paddr == OFS_COUNT) begin
                prdata_next = count_reg;
            end else if (paddr == OFS_INDEX) begin
                prdata_next = index_reg;
            end else if (paddr == OFS_STATUS) begin
                prdata_next = status;
            end else if (paddr == OFS_SRC_CUR) begin
                prdata_next = scur_reg;
            end else if (paddr == OFS_DST_CUR) begin
                prdata_next = dcur_reg;
            end else begin
                prdata_next = 32'h0000_0000;
            end
        end
        if (wr_acc) begin
            if (paddr == OFS_CTRL) begin
                ctrl_next = pwdata;
            end else if (paddr == OFS_SRC) begin
                src_next = pwdata;
            end else if (paddr == OFS_DST) begin
                dst_next = pwdata;
            end else if (paddr == OFS_COUNT) begin
                count_next = pwdata;
            end else if (paddr == OFS_INDEX) begin
                index_next = pwdata;
            end
        end
        case (state_reg)
            ST_IDLE: begin
                if (go) begin
                    scur_next  = src_reg;
                    dcur_next  = dst_reg;
                    eleft_next = count_reg[15:0];
                    fleft_next = count_reg[31:16];
                    first_next = 1'b1;
                    done_next  = 1'b0;
                    rdev_next  = rdev_set;
                    wrev_next  = wrev_set;
                    state_next = ST_RD_WAIT;
                end
            end
            ST_RD_WAIT: begin
                // Region is never consulted, so a boundary cannot stall
                if (!hold && (!read_sync_select_need || rdev_reg)) begin
                    rreq_next  = 1'b1;
                    state_next = ST_RD;
                end
            end
            ST_RD: begin
                if (rd_ack) begin
                    rreq_next  = 1'b0;
                    data_next  = rd_data;
                    scur_next  = step_addr(scur_reg, sstep, index_reg[15:0], index_reg[31:16],
                                           last_elem && ctrl_reg[CTL_SPLIT_BIT]);
                    state_next = ST_WR_WAIT;
                end
            end
            ST_WR_WAIT: begin
                if (!hold && (!write_sync_select_need || wrev_reg)) begin
                    wreq_next  = 1'b1;
                    state_next = ST_WR;
                end
            end
            ST_WR: begin
                if (wr_ack) begin
                    wreq_next  = 1'b0;
                    dcur_next  = step_addr(dcur_reg, dstep, index_reg[15:0], index_reg[31:16], last_elem);
                    first_next = last_elem;
                    eleft_next = eleft_reg - 16'h0001;
                    state_next = ST_RD_WAIT;
                    if (last_elem) begin
                        eleft_next = count_reg[15:0];
                        fleft_next = fleft_reg - 16'h0001;
                        if (fleft_reg <= 16'h0001) begin
                            done_next = 1'b1;
                            if (ctrl_reg[CTL_AUTO_BIT]) begin
                                scur_next  = src_reg;
                                dcur_next  = dst_reg;
                                fleft_next = count_reg[31:16];
                            end else begin
                                state_next = ST_IDLE;
                            end
                        end
                    end
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (wr_acc && paddr == OFS_CTRL && pwdata[CTL_START_LSB +: 2] == START_STOP) begin
            state_next = ST_IDLE;
            rreq_next  = 1'b0;
            wreq_next  = 1'b0;
        end
        rreg_next = region_of(rreq_next ? scur_next : scur_reg);
        wreg_next = region_of(wreq_next ? dcur_next : dcur_reg);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg   <= ST_IDLE;
            ctrl_reg    <= CTRL_RESET;
            src_reg     <= '0;
            dst_reg     <= '0;
            count_reg   <= '0;
            index_reg   <= '0;
            scur_reg    <= '0;
            dcur_reg    <= '0;
            eleft_reg   <= '0;
            fleft_reg   <= '0;
            first_reg   <= 1'b0;
            data_reg    <= '0;
            rdev_reg    <= 1'b0;
            wrev_reg    <= 1'b0;
            done_reg    <= 1'b0;
            rreq_reg    <= 1'b0;
            wreq_reg    <= 1'b0;
            rreg_reg    <= REG_PROG;
            wreg_reg    <= REG_PROG;
            prdata_reg  <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            ctrl_reg    <= ctrl_next;
            src_reg     <= src_next;
            dst_reg     <= dst_next;
            count_reg   <= count_next;
            index_reg   <= index_next;
            scur_reg    <= scur_next;
            dcur_reg    <= dcur_next;
            eleft_reg   <= eleft_next;
            fleft_reg   <= fleft_next;
            first_reg   <= first_next;
            data_reg    <= data_next;
            rdev_reg    <= rdev_next;
            wrev_reg    <= wrev_next;
            done_reg    <= done_next;
            rreq_reg    <= rreq_next;
            wreq_reg    <= wreq_next;
            rreg_reg    <= rreg_next;
            wreg_reg    <= wreg_next;
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata    = prdata_reg;
    assign pready    = pready_reg;
    assign pslverr   = pslverr_reg;
    assign rd_req    = rreq_reg;
    assign rd_addr   = scur_reg;
    assign rd_region = rreg_reg;
    assign wr_req    = wreq_reg;
    assign wr_addr   = dcur_reg;
    assign wr_data   = data_reg;
    assign wr_region = wreg_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_read_done;
        state_reg == ST_RD && rd_ack;
    endsequence
    sequence s_write_free;
        !hold && !write_sync_select_need && state_reg != ST_IDLE && !(wr_acc && paddr == OFS_CTRL);
    endsequence

    AST_NO_STALL: assert property (s_read_done ##1 s_write_free |=> wreq_reg)
        else $error("write not issued after read");
    AST_RD_HOST_WAIT: assert property (state_reg == ST_RD_WAIT && rsel == SEL_HOST && first_reg
        && !ctrl_reg[CTL_FSYNC_BIT] && !rdev_reg |=> !rreq_reg)
        else $error("read issued without host event");
    AST_WR_SYNC_WAIT: assert property (state_reg == ST_WR_WAIT && write_sync_select_need && !wrev_reg
        |=> !wreq_reg)
        else $error("write issued without sync event");
    AST_EMU_PAUSE: assert property (emulation_pause_enable && emu_halt && state_reg == ST_RD_WAIT |=> !rreq_reg)
        else $error("read issued during emulation halt");
    AST_EMU_RUN: assert property (!emulation_pause_enable && emu_halt && state_reg == ST_WR_WAIT && !write_sync_select_need
        && ctrl_reg[CTL_START_LSB +: 2] == START_RUN && !wr_acc |=> wreq_reg)
        else $error("write stalled by halt with emulation bit clear");
    AST_EVT_CONSUME: assert property (wreq_reg && wr_ack && write_sync_select_need && !wrev_set
        |=> !wrev_reg)
        else $error("write event not cleared after use");
    AST_SRC_INC: assert property (s_read_done and (sstep == STEP_INC)
        |=> scur_reg == $past(scur_reg) + ELEM_BYTES)
        else $error("source did not post-increment");
    AST_FRAME_IDX: assert property (s_read_done and (sstep == STEP_INDEX && last_elem
        && ctrl_reg[CTL_SPLIT_BIT]) |=> scur_reg == $past(scur_reg)
        + {{16{$past(index_reg[31])}}, $past(index_reg[31:16])})
        else $error("frame index not used at frame end");
    AST_START_CLEAR: assert property (go && !rdev_set |=> !rdev_reg)
        else $error("stale read event kept over start");
endmodule
`default_nettype wire

// file: hdl/dcs_pkg.sv
package dcs_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_SRC      = 8'h04;
    localparam logic [7:0] OFS_DST      = 8'h08;
    localparam logic [7:0] OFS_COUNT    = 8'h0c;
    localparam logic [7:0] OFS_INDEX    = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;
    localparam logic [7:0] OFS_SRC_CUR  = 8'h18;
    localparam logic [7:0] OFS_DST_CUR  = 8'h1c;
    // ----------------------------------------
    // Control field positions
    // ----------------------------------------
    localparam int CTL_START_LSB  = 0;
    localparam int CTL_EMU_BIT    = 2;
    localparam int CTL_AUTO_BIT   = 3;
    localparam int CTL_SPLIT_BIT  = 4;
    localparam int CTL_RSEL_LSB   = 5;
    localparam int CTL_WSEL_LSB   = 10;
    localparam int CTL_SSTEP_LSB  = 15;
    localparam int CTL_DSTEP_LSB  = 17;
    localparam int CTL_FSYNC_BIT  = 19;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // ----------------------------------------
    // Encodings
    // ----------------------------------------
    localparam logic [1:0] START_STOP  = 2'h0;
    localparam logic [1:0] START_RUN   = 2'h1;
    localparam logic [1:0] START_PAUSE = 2'h2;
    localparam logic [1:0] STEP_HOLD   = 2'h0;
    localparam logic [1:0] STEP_INC    = 2'h1;
    localparam logic [1:0] STEP_DEC    = 2'h2;
    localparam logic [1:0] STEP_INDEX  = 2'h3;
    localparam logic [4:0] SEL_NONE    = 5'h00;
    localparam logic [4:0] SEL_EXT4    = 5'h04;
    localparam logic [4:0] SEL_HOST    = 5'h10;
    localparam logic [31:0] ELEM_BYTES = 32'h0000_0004;
    // ----------------------------------------
    // Port regions
    // ----------------------------------------
    localparam logic [31:0] EXT_BASE    = 32'h0100_0000;
    localparam logic [31:0] PERIPH_BASE = 32'h0200_0000;
    localparam logic [1:0]  REG_PROG    = 2'h0;
    localparam logic [1:0]  REG_EXT     = 2'h1;
    localparam logic [1:0]  REG_PERIPH  = 2'h2;
    localparam int SYNC_STAGES = 2;
endpackage

// file: hdl/dcs_event_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dcs_event_sync #(
    parameter int N = 5
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [N-1:0] async_in,
    output logic      [N-1:0] rise_pulse
);
    import dcs_pkg::*;
    logic [N-1:0] meta_reg;
    logic [N-1:0] sync_reg;
    logic [N-1:0] prev_reg;
    logic [N-1:0] pulse_reg;
    logic [N-1:0] pulse_next;

    always_comb begin
        pulse_next = sync_reg & ~prev_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg  <= '0;
            sync_reg  <= '0;
            prev_reg  <= '0;
            pulse_reg <= '0;
        end else begin
            meta_reg  <= async_in;
            sync_reg  <= meta_reg;
            prev_reg  <= sync_reg;
            pulse_reg <= pulse_next;
        end
    end

    assign rise_pulse = pulse_reg;
endmodule
`default_nettype wire

// file: tb/dcs_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcs_mem_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        slow,
    input  wire logic        rd_req,
    input  wire logic [31:0] rd_addr,
    output logic             rd_ack,
    output logic      [31:0] rd_data,
    input  wire logic        wr_req,
    output logic             wr_ack
);
    int rd_wait;
    int wr_wait;
    // ----------------------------------------
    // Random latency, read data is inverted address
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ack  <= 1'b0;
            wr_ack  <= 1'b0;
            rd_data <= 32'h5a5a_a5a5;
            rd_wait <= 0;
            wr_wait <= 0;
        end else begin
            rd_ack  <= 1'b0;
            wr_ack  <= 1'b0;
            rd_data <= ~rd_data;
            if (rd_req && !rd_ack) begin
                if (rd_wait == 0) begin
                    rd_ack  <= 1'b1;
                    rd_data <= ~rd_addr;
                    rd_wait <= $urandom % 4 + (slow ? 6 : 0);
                end else begin
                    rd_wait <= rd_wait - 1;
                end
            end
            if (wr_req && !wr_ack) begin
                if (wr_wait == 0) begin
                    wr_ack  <= 1'b1;
                    wr_wait <= $urandom % 4 + (slow ? 6 : 0);
                end else begin
                    wr_wait <= wr_wait - 1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/dcs_channel_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
module dcs_channel_tb_top;
    import dcs_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, emu_halt, slow, chk_on;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_addr, rd_data, wr_addr, wr_data, q, s, d;
    logic [4:0]  ev;
    logic        rd_req, rd_ack, wr_req, wr_ack, e;
    logic [1:0]  rd_region, wr_region;
    logic [65:0] expq[$];
    logic [65:0] x;
    int          miscompares = 0, comparisons = 0, cyc = 0, rcnt = 0, wcnt = 0, r0, w0;
    always #20 pclk = ~pclk;
    dcs_channel dcs_channel_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .emu_halt(emu_halt), .host_to_processor_event(ev[0]),
        .external_interrupt_four(ev[1]), .external_interrupt_five(ev[2]),
        .external_interrupt_six(ev[3]), .external_interrupt_seven(ev[4]), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_region(rd_region), .rd_ack(rd_ack), .rd_data(rd_data),
        .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .wr_region(wr_region), .wr_ack(wr_ack));
    dcs_mem_model dcs_mem_model_inst (.pclk(pclk), .presetn(presetn), .slow(slow), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .wr_req(wr_req), .wr_ack(wr_ack));
    // ----------------------------------------
    // Verdict and hang guard
    // ----------------------------------------
    task results;
        if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            results();
        end
    end
    // ----------------------------------------
    // Memory port watcher
    // ----------------------------------------
    always @(posedge pclk) begin
        if (rd_req && rd_ack) rcnt++;
        if (wr_req && wr_ack) begin
            wcnt++;
            if (chk_on && expq.size() == 0) `CHK("extra_write", 1'b0, 1'b1)
            else if (chk_on) begin
                x = expq.pop_front();
                `CHK("wr_addr", x[65:34], wr_addr)
                `CHK("wr_data", x[33:2], wr_data)
                `CHK("wr_region", x[1:0], wr_region)
            end
        end
    end
    // ----------------------------------------
    // Bus and sequence tasks
    // ----------------------------------------
    task apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= dt;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    function logic [1:0] reg_of(input logic [31:0] a);
        return a >= PERIPH_BASE ? REG_PERIPH : (a >= EXT_BASE ? REG_EXT : REG_PROG);
    endfunction
    function logic [31:0] ctl(input logic [4:0] rs, input logic [4:0] ws, input logic em, input logic au);
        return 32'(START_RUN) | (32'(em) << CTL_EMU_BIT) | (32'(au) << CTL_AUTO_BIT)
            | (32'(rs) << CTL_RSEL_LSB) | (32'(ws) << CTL_WSEL_LSB)
            | (32'(STEP_INC) << CTL_SSTEP_LSB) | (32'(STEP_DEC) << CTL_DSTEP_LSB);
    endfunction
    task go(input logic [31:0] c, input int n, input logic note);
        logic [31:0] sa, da;
        sa = s;
        da = d;
        for (int i = 0; i < n && note; i++) begin
            expq.push_back({da, ~sa, reg_of(da)});
            sa = sa + ELEM_BYTES;
            da = da - ELEM_BYTES;
        end
        apb(1'b1, OFS_SRC, s);
        apb(1'b1, OFS_DST, d);
        apb(1'b1, OFS_COUNT, {16'h0001, 16'(n)});
        apb(1'b1, OFS_CTRL, c);
    endtask
    task wait_done;
        for (int i = 0; i < 300; i++) begin
            apb(1'b0, OFS_STATUS, 32'h0);
            if (q[0] === 1'b0) break;
        end
        `CHK("idle", 1'b0, q[0])
    endtask
    task pulse(input int i);
        @(posedge pclk);
        ev[i] <= 1'b1;
        repeat (2 + $urandom % 3) @(posedge pclk);
        ev[i] <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hc120c913));
        {psel, penable, pwrite, paddr, pwdata, emu_halt, ev, slow} = '0;
        chk_on  = 1'b1;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK("ctrl_reset", CTRL_RESET, q)
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped_err", 1'b1, e)
        for (int k = 0; k < 2; k++) begin
            s = (k == 0 ? EXT_BASE : PERIPH_BASE) - 32'h8;
            d = (k == 0 ? PERIPH_BASE : EXT_BASE) + 32'h8;
            go(ctl(SEL_NONE, SEL_NONE, 1'b0, 1'b0), 3, 1'b1);
            wait_done();
        end
        slow <= 1'b1;
        r0 = rcnt;
        go(ctl(SEL_NONE, SEL_NONE, 1'b0, 1'b0), 3, 1'b1);
        for (int i = 0; i < 200 && rcnt < r0 + 2; i++) @(posedge pclk);
        apb(1'b1, OFS_CTRL, ctl(SEL_NONE, SEL_NONE, 1'b0, 1'b0) ^ 32'(START_RUN ^ START_PAUSE));
        repeat (20) @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK("paused", 1'b1, q[1])
        apb(1'b1, OFS_CTRL, ctl(SEL_NONE, SEL_NONE, 1'b0, 1'b0));
        wait_done();
        slow <= 1'b0;
        s = EXT_BASE;
        d = PERIPH_BASE;
        for (int j = 0; j < 5; j++) begin
            r0 = rcnt;
            go(ctl(j == 0 ? SEL_HOST : SEL_EXT4 + 5'(j - 1), SEL_NONE, 1'b0, 1'b0), 1, 1'b1);
            repeat (30) @(posedge pclk);
            `CHK("read_held", r0, rcnt)
            pulse(j);
            wait_done();
            `CHK("one_read", r0 + 1, rcnt)
        end
        pulse(0);
        w0 = wcnt;
        go(ctl(SEL_NONE, SEL_HOST, 1'b0, 1'b0), 1, 1'b1);
        repeat (30) @(posedge pclk);
        `CHK("stale_event", w0, wcnt)
        pulse(0);
        wait_done();
        `CHK("write_synced", w0 + 1, wcnt)
        // Split mode, two frames of two, source indexed
        s = 32'h0000_1000;
        d = EXT_BASE;
        for (int i = 0; i < 4; i++) begin
            expq.push_back({d + 32'(4 * i), ~(s + 32'(16 * (i - i / 2) + 256 * (i / 2))), REG_EXT});
        end
        apb(1'b1, OFS_INDEX, 32'h0100_0010);
        apb(1'b1, OFS_SRC, s);
        apb(1'b1, OFS_DST, d);
        apb(1'b1, OFS_COUNT, 32'h0002_0002);
        apb(1'b1, OFS_CTRL, 32'(START_RUN) | (32'h1 << CTL_SPLIT_BIT) | (32'(STEP_INDEX) << CTL_SSTEP_LSB)
            | (32'(STEP_INC) << CTL_DSTEP_LSB));
        wait_done();
        chk_on = 1'b0;
        for (int m = 1; m >= 0; m--) begin
            emu_halt <= 1'b1;
            go(ctl(SEL_NONE, SEL_NONE, 1'(m), 1'b1), 2, 1'b0);
            w0 = wcnt;
            repeat (60) @(posedge pclk);
            if (m == 1) `CHK("halt_pause", w0, wcnt)
            else `CHK("halt_run", 1'b1, wcnt >= w0 + 4)
            emu_halt <= 1'b0;
            repeat (20) @(posedge pclk);
            apb(1'b1, OFS_CTRL, 32'h0);
            repeat (30) @(posedge pclk);
        end
        `CHK("left_over", 0, expq.size())
        results();
    end
endmodule
`default_nettype wire
